/* File: core/dfm_defines.svh */
`ifndef DFM_DEFINES_SVH
`define DFM_DEFINES_SVH

`define DFM_NBLK            4
`define DFM_BLK_UV          0
`define DFM_BLK_OV          1
`define DFM_BLK_TEMP        2
`define DFM_BLK_COMM        3

`define DFM_CLK_HZ          125000000
`define DFM_REPORT_S        1
`define DFM_HOLDOFF_S       5
`define DFM_MS_PER_S        1000

`define DFM_REG_STATUS      8'h00
`define DFM_REG_UV_THR      8'h04
`define DFM_REG_OV_THR      8'h08
`define DFM_REG_V_MARGIN    8'h0c
`define DFM_REG_T_THR       8'h10
`define DFM_REG_T_MARGIN    8'h14
`define DFM_REG_COMM_TMO    8'h18
`define DFM_BLK_FIRST       4'h2
`define DFM_BLK_LAST        4'h5
`define DFM_BLK_CFG         4'h0
`define DFM_BLK_SPN         4'h4
`define DFM_BLK_DELAY       4'h8
`define DFM_BLK_DTC         4'hc

`define DFM_CFG_DET_EN      0
`define DFM_CFG_KILL        1
`define DFM_CFG_REP_EN      2
`define DFM_CFG_STICKY      3
`define DFM_CFG_LAMP_LSB    4
`define DFM_CFG_FMI_LSB     8

`define DFM_RST_UV_THR      16'h2328
`define DFM_RST_OV_THR      16'h7530
`define DFM_RST_V_MARGIN    16'h01f4
`define DFM_RST_T_THR       16'h0069
`define DFM_RST_T_MARGIN    16'h0005
`define DFM_RST_COMM_TMO    16'h03e8
`define DFM_RST_LAMP        2'h1
`define DFM_RST_FMI_LOW     5'h01
`define DFM_RST_SPN         19'h7f000
`define DFM_RST_DELAY       16'h03e8

`define DFM_RESP_OKAY       2'h0
`define DFM_RESP_SLVERR     2'h2
`define DFM_DEST_GLOBAL     8'hff

`endif

/* File: core/dfm_pkg.sv */
`include "dfm_defines.svh"

package dfm_pkg;

  typedef enum logic [1:0] {
    DFM_REQ_ACTIVE,
    DFM_REQ_PREV,
    DFM_REQ_CLR_PREV,
    DFM_REQ_CLR_ACTIVE
  } dfm_req_kind_t;

  typedef enum logic [1:0] {
    DFM_TX_SINGLE,
    DFM_TX_BAM,
    DFM_TX_TP
  } dfm_txmode_t;

  typedef enum logic {
    DFM_TXS_IDLE,
    DFM_TXS_BUSY
  } dfm_txs_t;

  typedef struct packed {
    logic          valid;
    dfm_req_kind_t kind;
    logic [7:0]    src;
  } dfm_req_in_t;

  typedef struct packed {
    logic                      valid;
    dfm_txmode_t               mode;
    logic                      prev_list;
    logic [7:0]                dest;
    logic [7:0]                lamp;
    logic [2:0]                count;
    logic [`DFM_NBLK-1:0]      mask;
    logic [`DFM_NBLK-1:0][31:0] dtc;
  } dfm_tx_t;

  typedef struct packed {
    logic        det_en;
    logic        kill;
    logic        rep_en;
    logic        sticky;
    logic [1:0]  lamp;
    logic [4:0]  fmi;
    logic [18:0] spn;
    logic [15:0] qdly;
  } dfm_cfg_t;

  typedef struct packed {
    logic        flag;
    logic        qual;
    logic        active;
    logic        prev;
    logic [6:0]  oc;
    logic [15:0] qcnt;
  } dfm_blk_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } dfm_axi_t;

endpackage

/* File: core/dfm_top.sv */
// Contract
// - Detection off ignores that block's faults
// - Supply/temperature faults kill outputs if enabled
// - Low fault clears at threshold plus margin
// - High fault clears at threshold minus margin
// - Voltage blocks share margin, own kill
// - Code settings act only with reporting enabled
// - Code is SPN, FMI, zero bit, count
// - Report every second while reporting enabled
// - Report at once when any code turns active or the last active code clears
// - Many codes: BAM broadcast, TP to requester
// - No report broadcasts for five seconds
// - Qualify delay, then active, count, report
// - Non-sticky codes drop when condition clears
// - Previous list and clears only on request
// - First byte carries selected lamp bits
// - New parameter number zeroes occurrence count
// - New failure mode zeroes occurrence count
// - High failure mode derived from low mode
// - Unmapped modes shared, counts kept apart
// - Supply both sides, temperature/comm high only
`timescale 1ns/1ps
`include "dfm_defines.svh"

module dfm_top #(
  parameter logic [31:0] MS_CYCLES   = `DFM_CLK_HZ / `DFM_MS_PER_S,
  parameter logic [31:0] SEC_CYCLES  = `DFM_CLK_HZ * `DFM_REPORT_S,
  parameter logic [31:0] HOLD_CYCLES = `DFM_CLK_HZ * `DFM_HOLDOFF_S
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [7:0]           araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire logic [15:0]          supply_meas,
  input  wire logic [15:0]          temp_meas,
  input  wire logic                 rx_msg_seen,
  input  wire dfm_pkg::dfm_req_in_t req,
  output dfm_pkg::dfm_tx_t          tx,
  input  wire logic                 tx_ready,
  output logic                      outputs_off
);

  typedef struct packed {
    dfm_pkg::dfm_axi_t                    axi;
    dfm_pkg::dfm_cfg_t [`DFM_NBLK-1:0]    cfg;
    dfm_pkg::dfm_blk_t [`DFM_NBLK-1:0]    blk;
    logic [15:0]                          uv_thr;
    logic [15:0]                          ov_thr;
    logic [15:0]                          v_margin;
    logic [15:0]                          t_thr;
    logic [15:0]                          t_margin;
    logic [15:0]                          comm_tmo;
    logic [15:0]                          comm_ms;
    logic [31:0]                          ms_cnt;
    logic [31:0]                          sec_cnt;
    logic [31:0]                          hold_cnt;
    logic                                 hold_done;
    logic                                 pend_bcast;
    logic                                 pend_reply;
    logic                                 reply_prev;
    logic [7:0]                           reply_src;
    dfm_pkg::dfm_txs_t                    txs;
    dfm_pkg::dfm_tx_t                     tx;
    logic                                 outputs_off;
  } dfm_state_t;

  dfm_state_t s_q;
  dfm_state_t s_d;

  function automatic logic [4:0] high_fmi(input logic [4:0] low);
    logic [4:0] r;
    r = low;
    unique case (low)
      5'h01:   r = 5'h00;
      5'h04:   r = 5'h03;
      5'h05:   r = 5'h06;
      5'h11:   r = 5'h0f;
      5'h12:   r = 5'h10;
      5'h15:   r = 5'h14;
      default: r = low;
    endcase
    return r;
  endfunction

  // Only blocks that watch a ceiling report the derived high-side mode
  function automatic logic [31:0] make_dtc(input dfm_pkg::dfm_cfg_t c, input logic [6:0] oc,
                                           input logic hi);
    logic [4:0] f;
    f = hi ? high_fmi(c.fmi) : c.fmi;
    return {oc, 1'b0, f, c.spn};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    for (int b = 0; b < 4; b++) begin
      m[8*b +: 8] = {8{be[b]}};
    end
    return (old & ~m) | (wd & m);
  endfunction

  function automatic logic blk_high(input int i);
    return i != `DFM_BLK_UV;
  endfunction

  always_comb begin
    logic                  ms_tick;
    logic                  sec_tick;
    logic                  any_rep;
    logic                  any_act_q;
    logic                  any_act_d;
    logic                  new_evt;
    logic                  trip;
    logic                  clr;
    logic                  qual_now;
    logic                  hi;
    logic [15:0]           meas;
    logic [15:0]           thr;
    logic [15:0]           mrg;
    logic [31:0]           wv;
    logic [31:0]           rv;
    logic [3:0]            bsel;
    logic [1:0]            rsp;
    logic [`DFM_NBLK-1:0]  mask;
    logic [2:0]            cnt;
    logic [7:0]            lamp;
    dfm_pkg::dfm_cfg_t     c;
    ms_tick   = (s_q.ms_cnt == MS_CYCLES - 32'h1);
    sec_tick  = (s_q.sec_cnt == SEC_CYCLES - 32'h1);
    any_rep   = 1'b0;
    any_act_q = 1'b0;
    any_act_d = 1'b0;
    new_evt   = 1'b0;
    trip      = 1'b0;
    clr       = 1'b0;
    qual_now  = 1'b0;
    hi        = 1'b0;
    meas      = '0;
    thr       = '0;
    mrg       = '0;
    wv        = '0;
    rv        = '0;
    bsel      = '0;
    rsp       = `DFM_RESP_OKAY;
    mask      = '0;
    cnt       = '0;
    lamp      = '0;
    c         = '0;
    s_d       = s_q;

    s_d.ms_cnt  = ms_tick ? '0 : s_q.ms_cnt + 32'h1;
    s_d.sec_cnt = sec_tick ? '0 : s_q.sec_cnt + 32'h1;
    if (!s_q.hold_done) begin
      s_d.hold_cnt  = s_q.hold_cnt + 32'h1;
      s_d.hold_done = (s_q.hold_cnt == HOLD_CYCLES - 32'h1);
    end
    if (rx_msg_seen) begin
      s_d.comm_ms = '0;
    end else if (ms_tick && s_q.comm_ms != 16'hffff) begin
      s_d.comm_ms = s_q.comm_ms + 16'h1;
    end

    // Requests from the network; clears act before qualification so a new fault wins
    if (req.valid) begin
      unique case (req.kind)
        dfm_pkg::DFM_REQ_ACTIVE, dfm_pkg::DFM_REQ_PREV: begin
          s_d.pend_reply = 1'b1;
          s_d.reply_prev = (req.kind == dfm_pkg::DFM_REQ_PREV);
          s_d.reply_src  = req.src;
        end
        dfm_pkg::DFM_REQ_CLR_PREV: begin
          for (int i = 0; i < `DFM_NBLK; i++) begin
            s_d.blk[i].prev = 1'b0;
          end
        end
        dfm_pkg::DFM_REQ_CLR_ACTIVE: begin
          for (int i = 0; i < `DFM_NBLK; i++) begin
            if (s_q.blk[i].active) begin
              s_d.blk[i].active = 1'b0;
              s_d.blk[i].prev   = 1'b1;
            end
          end
        end
      endcase
    end

    // Register bus: address and data are taken together, one cycle after both arrive
    s_d.axi.awready = awvalid && wvalid && !s_q.axi.awready && !s_q.axi.bvalid;
    s_d.axi.wready  = s_d.axi.awready;
    if (s_q.axi.bvalid && bready) begin
      s_d.axi.bvalid = 1'b0;
    end
    if (s_q.axi.awready) begin
      bsel = awaddr[7:4] - `DFM_BLK_FIRST;
      if (awaddr[7:4] >= `DFM_BLK_FIRST && awaddr[7:4] <= `DFM_BLK_LAST) begin
        c = s_q.cfg[bsel[1:0]];
        unique case ({awaddr[3:2], 2'b00})
          `DFM_BLK_CFG: begin
            wv = merge({19'h0, c.fmi, 2'h0, c.lamp, c.sticky, c.rep_en, c.kill, c.det_en},
                       wdata, wstrb);
            s_d.cfg[bsel[1:0]].det_en = wv[`DFM_CFG_DET_EN];
            s_d.cfg[bsel[1:0]].kill   = wv[`DFM_CFG_KILL];
            s_d.cfg[bsel[1:0]].rep_en = wv[`DFM_CFG_REP_EN];
            s_d.cfg[bsel[1:0]].sticky = wv[`DFM_CFG_STICKY];
            s_d.cfg[bsel[1:0]].lamp   = wv[`DFM_CFG_LAMP_LSB +: 2];
            s_d.cfg[bsel[1:0]].fmi    = wv[`DFM_CFG_FMI_LSB +: 5];
            if (wv[`DFM_CFG_FMI_LSB +: 5] != c.fmi) begin
              s_d.blk[bsel[1:0]].oc = '0;
            end
          end
          `DFM_BLK_SPN: begin
            wv = merge({13'h0, c.spn}, wdata, wstrb);
            s_d.cfg[bsel[1:0]].spn = wv[18:0];
            if (wv[18:0] != c.spn) begin
              s_d.blk[bsel[1:0]].oc = '0;
            end
          end
          `DFM_BLK_DELAY: begin
            wv = merge({16'h0, c.qdly}, wdata, wstrb);
            s_d.cfg[bsel[1:0]].qdly = wv[15:0];
          end
          default: ;
        endcase
      end else begin
        unique case ({awaddr[7:2], 2'b00})
          `DFM_REG_STATUS: ;
          `DFM_REG_UV_THR:   s_d.uv_thr   = 16'(merge({16'h0, s_q.uv_thr}, wdata, wstrb));
          `DFM_REG_OV_THR:   s_d.ov_thr   = 16'(merge({16'h0, s_q.ov_thr}, wdata, wstrb));
          `DFM_REG_V_MARGIN: s_d.v_margin = 16'(merge({16'h0, s_q.v_margin}, wdata, wstrb));
          `DFM_REG_T_THR:    s_d.t_thr    = 16'(merge({16'h0, s_q.t_thr}, wdata, wstrb));
          `DFM_REG_T_MARGIN: s_d.t_margin = 16'(merge({16'h0, s_q.t_margin}, wdata, wstrb));
          `DFM_REG_COMM_TMO: s_d.comm_tmo = 16'(merge({16'h0, s_q.comm_tmo}, wdata, wstrb));
          default:           rsp = `DFM_RESP_SLVERR;
        endcase
      end
      s_d.axi.bvalid = 1'b1;
      s_d.axi.bresp  = rsp;
    end

    // Fault detection, qualification and code state per block
    s_d.outputs_off = 1'b0;
    for (int i = 0; i < `DFM_NBLK; i++) begin
      c  = s_d.cfg[i];
      hi = blk_high(i);
      any_rep   = any_rep | c.rep_en;
      any_act_q = any_act_q | s_q.blk[i].active;
      if (i == `DFM_BLK_UV || i == `DFM_BLK_OV) begin
        meas = supply_meas;
        thr  = (i == `DFM_BLK_UV) ? s_q.uv_thr : s_q.ov_thr;
        mrg  = s_q.v_margin;
      end else if (i == `DFM_BLK_TEMP) begin
        meas = temp_meas;
        thr  = s_q.t_thr;
        mrg  = s_q.t_margin;
      end else begin
        meas = s_q.comm_ms;
        thr  = s_q.comm_tmo;
        mrg  = '0;
      end
      trip = hi ? (meas > thr) : (meas < thr);
      clr  = hi ? ({1'b0, meas} + {1'b0, mrg} <= {1'b0, thr})
                : ({1'b0, meas} >= {1'b0, thr} + {1'b0, mrg});
      if (!c.det_en) begin
        s_d.blk[i].flag = 1'b0;
      end else if (!s_q.blk[i].flag && trip) begin
        s_d.blk[i].flag = 1'b1;
      end else if (s_q.blk[i].flag && clr) begin
        s_d.blk[i].flag = 1'b0;
      end
      if (s_d.blk[i].flag && !s_q.blk[i].flag) begin
        s_d.blk[i].qcnt = c.qdly;
      end else if (ms_tick && s_q.blk[i].qcnt != '0) begin
        s_d.blk[i].qcnt = s_q.blk[i].qcnt - 16'h1;
      end
      if (!s_d.blk[i].flag) begin
        s_d.blk[i].qual = 1'b0;
      end
      qual_now = s_q.blk[i].flag && s_d.blk[i].flag && !s_q.blk[i].qual && c.rep_en
                 && s_q.blk[i].qcnt == '0;
      if (qual_now) begin
        s_d.blk[i].active = 1'b1;
        s_d.blk[i].qual   = 1'b1;
        new_evt = new_evt | !s_q.blk[i].active;
        if (s_q.blk[i].oc != 7'h7f) begin
          s_d.blk[i].oc = s_d.blk[i].oc + 7'h1;
        end
      end else if (s_q.blk[i].active && !s_d.blk[i].flag && !c.sticky) begin
        s_d.blk[i].active = 1'b0;
        s_d.blk[i].prev   = 1'b1;
      end
      if (!c.rep_en) begin
        s_d.blk[i].active = 1'b0;
      end
      if (i != `DFM_BLK_COMM && c.kill && s_d.blk[i].flag) begin
        s_d.outputs_off = 1'b1;
      end
      any_act_d = any_act_d | s_d.blk[i].active;
    end

    // Broadcast requests are set after the issue clears them, so none is lost
    if (s_q.txs == dfm_pkg::DFM_TXS_IDLE && (s_q.pend_reply || (s_q.pend_bcast && s_q.hold_done))) begin
      for (int i = 0; i < `DFM_NBLK; i++) begin
        c       = s_q.cfg[i];
        mask[i] = c.rep_en && (s_q.pend_reply && s_q.reply_prev ? s_q.blk[i].prev
                                                                 : s_q.blk[i].active);
        cnt     = cnt + 3'(mask[i]);
        if (c.rep_en && s_q.blk[i].active) begin
          lamp = lamp | (8'h01 << {c.lamp, 1'b0});
        end
        s_d.tx.dtc[i] = make_dtc(c, s_q.blk[i].oc, blk_high(i));
      end
      s_d.tx.mask  = mask;
      s_d.tx.count = cnt;
      s_d.tx.lamp  = lamp;
      s_d.txs      = dfm_pkg::DFM_TXS_BUSY;
      if (s_q.pend_reply) begin
        s_d.pend_reply   = req.valid && !req.kind[1];
        s_d.tx.prev_list = s_q.reply_prev;
        s_d.tx.dest      = s_q.reply_src;
        s_d.tx.mode      = cnt > 3'h1 ? dfm_pkg::DFM_TX_TP : dfm_pkg::DFM_TX_SINGLE;
      end else begin
        s_d.pend_bcast   = 1'b0;
        s_d.tx.prev_list = 1'b0;
        s_d.tx.dest      = `DFM_DEST_GLOBAL;
        s_d.tx.mode      = cnt > 3'h1 ? dfm_pkg::DFM_TX_BAM : dfm_pkg::DFM_TX_SINGLE;
      end
    end else if (s_q.txs == dfm_pkg::DFM_TXS_BUSY && tx_ready) begin
      s_d.txs = dfm_pkg::DFM_TXS_IDLE;
    end
    s_d.tx.valid = (s_d.txs == dfm_pkg::DFM_TXS_BUSY);
    if ((sec_tick && any_rep) || new_evt || (any_act_q && !any_act_d && any_rep)) begin
      s_d.pend_bcast = 1'b1;
    end

    // Register reads
    s_d.axi.arready = arvalid && !s_q.axi.arready && !s_q.axi.rvalid;
    if (s_q.axi.rvalid && rready) begin
      s_d.axi.rvalid = 1'b0;
    end
    if (s_q.axi.arready) begin
      rsp  = `DFM_RESP_OKAY;
      bsel = araddr[7:4] - `DFM_BLK_FIRST;
      if (araddr[7:4] >= `DFM_BLK_FIRST && araddr[7:4] <= `DFM_BLK_LAST) begin
        c = s_q.cfg[bsel[1:0]];
        unique case ({araddr[3:2], 2'b00})
          `DFM_BLK_CFG:   rv = {19'h0, c.fmi, 2'h0, c.lamp, c.sticky, c.rep_en, c.kill, c.det_en};
          `DFM_BLK_SPN:   rv = {13'h0, c.spn};
          `DFM_BLK_DELAY: rv = {16'h0, c.qdly};
          default:        rv = make_dtc(c, s_q.blk[bsel[1:0]].oc, bsel[1:0] != 2'(`DFM_BLK_UV));
        endcase
      end else begin
        unique case ({araddr[7:2], 2'b00})
          `DFM_REG_STATUS: begin
            for (int i = 0; i < `DFM_NBLK; i++) begin
              rv[i]      = s_q.blk[i].active;
              rv[4 + i]  = s_q.blk[i].prev;
              rv[8 + i]  = s_q.blk[i].flag;
            end
            rv[12] = s_q.hold_done;
            rv[13] = s_q.outputs_off;
          end
          `DFM_REG_UV_THR:   rv = {16'h0, s_q.uv_thr};
          `DFM_REG_OV_THR:   rv = {16'h0, s_q.ov_thr};
          `DFM_REG_V_MARGIN: rv = {16'h0, s_q.v_margin};
          `DFM_REG_T_THR:    rv = {16'h0, s_q.t_thr};
          `DFM_REG_T_MARGIN: rv = {16'h0, s_q.t_margin};
          `DFM_REG_COMM_TMO: rv = {16'h0, s_q.comm_tmo};
          default:           rsp = `DFM_RESP_SLVERR;
        endcase
      end
      s_d.axi.rvalid = 1'b1;
      s_d.axi.rdata  = rv;
      s_d.axi.rresp  = rsp;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q          <= '0;
      s_q.uv_thr   <= `DFM_RST_UV_THR;
      s_q.ov_thr   <= `DFM_RST_OV_THR;
      s_q.v_margin <= `DFM_RST_V_MARGIN;
      s_q.t_thr    <= `DFM_RST_T_THR;
      s_q.t_margin <= `DFM_RST_T_MARGIN;
      s_q.comm_tmo <= `DFM_RST_COMM_TMO;
      s_q.txs      <= dfm_pkg::DFM_TXS_IDLE;
      for (int i = 0; i < `DFM_NBLK; i++) begin
        s_q.cfg[i].lamp <= `DFM_RST_LAMP;
        s_q.cfg[i].fmi  <= `DFM_RST_FMI_LOW;
        s_q.cfg[i].spn  <= `DFM_RST_SPN;
        s_q.cfg[i].qdly <= `DFM_RST_DELAY;
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign awready     = s_q.axi.awready;
  assign wready      = s_q.axi.wready;
  assign bvalid      = s_q.axi.bvalid;
  assign bresp       = s_q.axi.bresp;
  assign arready     = s_q.axi.arready;
  assign rvalid      = s_q.axi.rvalid;
  assign rresp       = s_q.axi.rresp;
  assign rdata       = s_q.axi.rdata;
  assign tx          = s_q.tx;
  assign outputs_off = s_q.outputs_off;

endmodule

/* File: bench/dfm_ecu_model.sv */
`timescale 1ns/1ps
module dfm_ecu_model (
  input  wire logic             aclk,
  input  wire dfm_pkg::dfm_tx_t tx,
  output logic                  tx_ready,
  output dfm_pkg::dfm_req_in_t  req
);
  dfm_pkg::dfm_tx_t bc_q;
  dfm_pkg::dfm_tx_t rep_q;
  int               n_bc = 0;
  logic [1:0]       ph = 2'h0;

  initial begin
    tx_ready = 1'b0;
    req = '0;
  end

  // Slow framer: one take in four cycles keeps messages waiting on the block
  always @(posedge aclk) begin
    ph <= ph + 2'h1;
    tx_ready <= (ph == 2'h3);
    if (tx.valid && tx_ready) begin
      if (tx.dest == 8'hff) begin
        bc_q <= tx;
        n_bc <= n_bc + 1;
      end else begin
        rep_q <= tx;
      end
    end
  end

  // Idle fields are inverted so a stale request can never pass for a fresh one
  task automatic ask(input dfm_pkg::dfm_req_kind_t k, input logic [7:0] s);
    @(posedge aclk);
    req <= '{valid: 1'b1, kind: k, src: s};
    @(posedge aclk);
    req <= '{valid: 1'b0, kind: dfm_pkg::dfm_req_kind_t'(~k), src: ~s};
  endtask
endmodule

/* File: bench/dfm_top_properties.sv */
`timescale 1ns/1ps
module dfm_top_chk #(
  parameter logic [31:0] HOLD_CYCLES = 32'h0000_0064
) (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             bvalid,
  input wire logic [1:0]       bresp,
  input wire logic             bready,
  input wire dfm_pkg::dfm_tx_t tx,
  input wire logic             tx_ready
);
  logic [31:0] up_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) up_q <= 32'h0;
    else up_q <= up_q + 32'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_holdoff_quiet: assert property (
    tx.valid && tx.dest == 8'hff |-> up_q >= HOLD_CYCLES) else $error("early broadcast");
  a_multi_bam: assert property (
    tx.valid && tx.dest == 8'hff && tx.count >= 3'h2 |-> tx.mode == dfm_pkg::DFM_TX_BAM)
    else $error("multi-code broadcast not BAM");
  a_multi_tp: assert property (
    tx.valid && tx.dest != 8'hff && tx.count >= 3'h2 |-> tx.mode == dfm_pkg::DFM_TX_TP)
    else $error("multi-code reply not TP");
  a_single_frame: assert property (
    tx.valid && tx.count < 3'h2 |-> tx.mode == dfm_pkg::DFM_TX_SINGLE)
    else $error("few codes not single frame");
  a_lamp_idle: assert property (
    tx.valid && !tx.prev_list && tx.mask == 4'h0 |-> tx.lamp == 8'h00)
    else $error("lamp lit with no code");
  a_cm_zero: assert property (
    tx.valid |-> !(tx.dtc[0][24] | tx.dtc[1][24] | tx.dtc[2][24] | tx.dtc[3][24]))
    else $error("conversion bit set");
  a_tx_hold: assert property (
    tx.valid && !tx_ready |=> tx.valid && $stable(tx)) else $error("message changed");
  a_resp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write response dropped");
endmodule

bind dfm_top dfm_top_chk #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .bvalid(bvalid), .bresp(bresp), .bready(bready), .tx(tx), .tx_ready(tx_ready));

/* File: bench/test_diag_fault_dtc_manager.sv */
`timescale 1ns/1ps
module test_diag_fault_dtc_manager;
  logic                 aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                 arvalid, arready, rvalid, rready, tx_ready, outputs_off;
  logic [7:0]           awaddr, araddr;
  logic [31:0]          wdata, rdata, d;
  logic [1:0]           bresp, rresp, r;
  logic [15:0]          supply_meas, temp_meas;
  dfm_pkg::dfm_req_in_t req;
  dfm_pkg::dfm_tx_t     tx;
  int                   error_cnt = 0, num_checks = 0, cyc = 0, n;
  logic [4:0]           lo [7] = '{5'h01, 5'h04, 5'h05, 5'h11, 5'h12, 5'h15, 5'h07};
  logic [4:0]           hi [7] = '{5'h00, 5'h03, 5'h06, 5'h0f, 5'h10, 5'h14, 5'h07};

  dfm_top #(.MS_CYCLES(32'h4), .SEC_CYCLES(32'h32), .HOLD_CYCLES(32'h64)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .supply_meas(supply_meas), .temp_meas(temp_meas), .rx_msg_seen(1'b0), .req(req),
    .tx(tx), .tx_ready(tx_ready), .outputs_off(outputs_off));
  dfm_ecu_model u_ecu (.aclk(aclk), .tx(tx), .tx_ready(tx_ready), .req(req));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    supply_meas = 16'h3000;
    temp_meas = 16'hffff;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h04, 32'h0000_2328);
    rchk(8'h0c, 32'h0000_01f4);
    rchk(8'h20, 32'h0000_0110);
    rchk(8'h24, 32'h0007_f000);
    rd(8'hfc);
    chk({30'h0, r}, 32'h2);
    wr(8'hf8, 32'h1);
    chk({30'h0, r}, 32'h2);
    wr(8'h28, 32'h0);
    wr(8'h20, 32'h0000_0115);
    supply_meas <= 16'h2327;
    repeat (4) @(posedge aclk);
    rchk(8'h00, 32'h0000_0101);
    chk(u_ecu.n_bc, 0);
    rchk(8'h2c, 32'h020f_f000);
    repeat (100) @(posedge aclk);
    chk({24'h0, u_ecu.bc_q.lamp}, 32'h04);
    chk(u_ecu.bc_q.dtc[0], 32'h020f_f000);
    supply_meas <= 16'h251b;
    repeat (4) @(posedge aclk);
    rchk(8'h00, 32'h0000_1101);
    n = u_ecu.n_bc;
    supply_meas <= 16'h251c;
    repeat (12) @(posedge aclk);
    chk({31'h0, u_ecu.n_bc > n}, 32'h1);
    chk({29'h0, u_ecu.bc_q.count}, 32'h0);
    rchk(8'h00, 32'h0000_1010);
    u_ecu.ask(dfm_pkg::DFM_REQ_PREV, 8'h21);
    repeat (12) @(posedge aclk);
    chk({23'h0, u_ecu.rep_q.prev_list, u_ecu.rep_q.dest}, 32'h121);
    u_ecu.ask(dfm_pkg::DFM_REQ_CLR_PREV, 8'h21);
    repeat (4) @(posedge aclk);
    rchk(8'h00, 32'h0000_1000);
    wr(8'h24, 32'h0001_2345);
    rchk(8'h2c, 32'h0009_2345);
    for (int i = 0; i < 7; i++) begin
      wr(8'h30, {19'h0, lo[i], 8'h00});
      rd(8'h3c);
      chk({27'h0, d[23:19]}, {27'h0, hi[i]});
    end
    wr(8'h30, 32'h0000_0003);
    supply_meas <= 16'h7531;
    repeat (4) @(posedge aclk);
    chk({31'h0, outputs_off}, 32'h1);
    supply_meas <= 16'h733d;
    repeat (4) @(posedge aclk);
    chk({31'h0, outputs_off}, 32'h1);
    supply_meas <= 16'h733c;
    repeat (4) @(posedge aclk);
    chk({31'h0, outputs_off}, 32'h0);
    wr(8'h48, 32'h0);
    wr(8'h40, 32'h0000_0115);
    supply_meas <= 16'h2000;
    repeat (70) @(posedge aclk);
    chk({29'h0, u_ecu.bc_q.count}, 32'h2);
    chk({30'h0, u_ecu.bc_q.mode}, {30'h0, dfm_pkg::DFM_TX_BAM});
    u_ecu.ask(dfm_pkg::DFM_REQ_ACTIVE, 8'h33);
    repeat (12) @(posedge aclk);
    chk({22'h0, u_ecu.rep_q.mode, u_ecu.rep_q.dest}, {22'h0, dfm_pkg::DFM_TX_TP, 8'h33});
    wr(8'h20, 32'h0000_0414);
    rchk(8'h2c, 32'h0021_2345);
    rchk(8'h00, 32'h0000_1414);
    report_and_stop();
  end
endmodule
